// *** src/ipz_port_zero.sv ***
// Port-zero input block: pin levels, pull modes and per-pin edge interrupts.
// Assumes pins synchronous to clk, a one-cycle slow tick, and a register port
// that never waits: read data stand in the cycle after the read strobe only.
`timescale 1ns/1ps

module ipz_port_zero #(
  parameter int NUM_PINS = 6
) (
  // Clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  // Register port
  input  wire ipz_pkg::ipz_bus_req_t         bus_req,
  output logic [ipz_pkg::DATA_W-1:0]         bus_rdata,
  // Pins and tick
  input  wire logic [ipz_pkg::MAX_PINS-1:0]  pin_in,
  input  wire logic                          slow_sampling_tick,
  // Pad pull controls
  output logic [ipz_pkg::MAX_PINS-1:0]       pull_up_en,
  output logic [ipz_pkg::MAX_PINS-1:0]       pull_down_en,
  // Alternate functions
  output logic                               pwm_unit_a_event_in,
  output logic                               pwm_unit_b_event_in,
  output logic                               serial0_receive_in,
  output logic                               serial1_receive_in,
  // Interrupt requests
  output logic [ipz_pkg::MAX_PINS-1:0]       external_irq
);
  import ipz_pkg::*;

  // ==========================================================================
  // Variant masks: absent pins stay zero; bits 7:6 stay zero in the pull and pin-level registers only
  localparam logic [REG_W-1:0] PIN_MASK  = (NUM_PINS == 5) ? PIN_MASK5 : PIN_MASK6;
  localparam logic [REG_W-1:0] EDGE_MASK = PIN_MASK | PORT3_MASK;

  logic [REG_W-1:0]  edge_low_r, edge_low_nxt;
  logic [REG_W-1:0]  edge_high_r, edge_high_nxt;
  logic [REG_W-1:0]  sample_sel_r, sample_sel_nxt;
  logic [REG_W-1:0]  pull_low_r, pull_low_nxt;
  logic [REG_W-1:0]  pull_high_r, pull_high_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [REG_W-1:0]  pin_level_bits;
  logic              wr_en;
  logic              hit_pull_word;
  logic              hit_edge_word;

  // Pins are already synchronous, so the level register is a live view
  assign pin_level_bits = {2'b00, pin_in} & PIN_MASK;

  // ==========================================================================
  // Register writes
  // While ce is low, writes are dropped along with edge-detector updates; read data still update.
  always_comb begin
    wr_en          = bus_req.wr & ce;
    hit_pull_word  = bus_req.word && (bus_req.addr == ADDR_PULL_LOW);
    hit_edge_word  = bus_req.word && (bus_req.addr == ADDR_EDGE_LOW);
    edge_low_nxt   = edge_low_r;
    edge_high_nxt  = edge_high_r;
    sample_sel_nxt = sample_sel_r;
    pull_low_nxt   = pull_low_r;
    pull_high_nxt  = pull_high_r;
    if (wr_en) begin
      case (bus_req.addr)
        ADDR_EDGE_LOW: begin
          edge_low_nxt = bus_req.wdata[REG_W-1:0] & EDGE_MASK;
          if (hit_edge_word) begin
            edge_high_nxt = bus_req.wdata[DATA_W-1:REG_W] & EDGE_MASK;
          end
        end
        ADDR_EDGE_HIGH: begin
          edge_high_nxt = bus_req.wdata[REG_W-1:0] & EDGE_MASK;
        end
        ADDR_SAMPLE_SEL: begin
          sample_sel_nxt = bus_req.wdata[REG_W-1:0] & EDGE_MASK;
        end
        ADDR_PULL_LOW: begin
          pull_low_nxt = bus_req.wdata[REG_W-1:0] & PIN_MASK;
          if (hit_pull_word) begin
            pull_high_nxt = bus_req.wdata[DATA_W-1:REG_W] & PIN_MASK;
          end
        end
        ADDR_PULL_HIGH: begin
          pull_high_nxt = bus_req.wdata[REG_W-1:0] & PIN_MASK;
        end
        // Pin-level register and unmapped addresses ignore writes
        default: begin
          edge_low_nxt = edge_low_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edge_low_r   <= RESET_CTRL;
      edge_high_r  <= RESET_CTRL;
      sample_sel_r <= RESET_CTRL;
      pull_low_r   <= RESET_CTRL;
      pull_high_r  <= RESET_CTRL;
    end else begin
      edge_low_r   <= edge_low_nxt;
      edge_high_r  <= edge_high_nxt;
      sample_sel_r <= sample_sel_nxt;
      pull_low_r   <= pull_low_nxt;
      pull_high_r  <= pull_high_nxt;
    end
  end

  // ==========================================================================
  // Register reads
  // Read data stand for one cycle only and are zero otherwise.
  always_comb begin
    rdata_nxt = {DATA_W{1'b0}};
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_EDGE_LOW: begin
          rdata_nxt = {(hit_edge_word ? edge_high_r : ZERO_BYTE), edge_low_r};
        end
        ADDR_EDGE_HIGH: begin
          rdata_nxt = {ZERO_BYTE, edge_high_r};
        end
        ADDR_SAMPLE_SEL: begin
          rdata_nxt = {ZERO_BYTE, sample_sel_r};
        end
        ADDR_PIN_LEVEL: begin
          rdata_nxt = {ZERO_BYTE, pin_level_bits};
        end
        ADDR_PULL_LOW: begin
          rdata_nxt = {(hit_pull_word ? pull_high_r : ZERO_BYTE), pull_low_r};
        end
        ADDR_PULL_HIGH: begin
          rdata_nxt = {ZERO_BYTE, pull_high_r};
        end
        default: begin
          rdata_nxt = {DATA_W{1'b0}};
        end
      endcase
    end
  end

  // A read in a frozen cycle still answers, so the master never waits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= {DATA_W{1'b0}};
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata = rdata_r;

  // ==========================================================================
  // Pull controls
  ipz_pull_decode #(
    .WIDTH(MAX_PINS)
  ) u_pull (
    .pull_select_low_bit  (pull_low_r[MAX_PINS-1:0]),
    .pull_select_high_bit (pull_high_r[MAX_PINS-1:0]),
    .pull_up_en           (pull_up_en),
    .pull_down_en         (pull_down_en)
  );

  // ==========================================================================
  // Alternate-function routing
  assign pwm_unit_a_event_in = pin_in[0];
  assign pwm_unit_b_event_in = pin_in[1];
  assign serial0_receive_in  = pin_in[2];
  assign serial1_receive_in  = pin_in[3];

  // ==========================================================================
  // Edge detectors, one per pin; absent pins get a tied-off request
  for (genvar g = 0; g < MAX_PINS; g++) begin : g_pin
    if (g < NUM_PINS) begin : g_on
      ipz_edge_bit u_edge (
        .clk                (clk),
        .rstn               (rstn),
        .ce                 (ce),
        .pin                (pin_in[g]),
        .slow_sampling_tick (slow_sampling_tick),
        .edge_mode          ({edge_high_r[g], edge_low_r[g]}),
        .sample_sel         (sample_sel_r[g]),
        .irq                (external_irq[g])
      );
    end else begin : g_off
      assign external_irq[g] = 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_rd_at(logic [ADDR_W-1:0] a);
    bus_req.rd && (bus_req.addr == a) && !bus_req.word;
  endsequence

  sequence s_word_wr_pull;
    ce && bus_req.wr && bus_req.word && (bus_req.addr == ADDR_PULL_LOW);
  endsequence

  AST_PIN_READ: assert property (@(posedge clk) disable iff (!rstn)
      s_rd_at(ADDR_PIN_LEVEL) |=> bus_rdata[REG_W-1:0] == ($past(pin_in) & PIN_MASK[5:0]))
    else $error("pin level read mismatch");

  AST_PIN_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      s_rd_at(ADDR_PIN_LEVEL) |=> bus_rdata[DATA_W-1:NUM_PINS] == '0)
    else $error("absent pin bits not zero");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      !bus_req.rd |=> bus_rdata == '0)
    else $error("read data outside read answer");

  AST_PULL_WORD: assert property (@(posedge clk) disable iff (!rstn)
      s_word_wr_pull |=> (pull_low_r == ($past(bus_req.wdata[7:0]) & PIN_MASK))
                         && (pull_high_r == ($past(bus_req.wdata[15:8]) & PIN_MASK)))
    else $error("pull word write not paired");

  AST_PULL_WORD_READ: assert property (@(posedge clk) disable iff (!rstn)
      (bus_req.rd && bus_req.word && bus_req.addr == ADDR_PULL_LOW)
      |=> bus_rdata == {$past(pull_high_r), $past(pull_low_r)})
    else $error("pull word read not paired");

  AST_RO_PIN_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
      (bus_req.wr && bus_req.addr == ADDR_PIN_LEVEL)
      |=> $stable(pull_low_r) && $stable(pull_high_r) && $stable(edge_low_r)
          && $stable(sample_sel_r))
    else $error("write to read-only register changed state");

  AST_PULL_UP_DECODE: assert property (@(posedge clk) disable iff (!rstn)
      (ce && bus_req.wr && !bus_req.word && bus_req.addr == ADDR_PULL_HIGH
       && bus_req.wdata[0] && !pull_low_r[0]) |=> pull_up_en[0] && !pull_down_en[0])
    else $error("pull-up not selected by code 10");

  AST_ROUTE: assert property (@(posedge clk) disable iff (!rstn)
      serial0_receive_in == pin_in[2] && serial1_receive_in == pin_in[3]
      && pwm_unit_a_event_in == pin_in[0] && pwm_unit_b_event_in == pin_in[1])
    else $error("alternate routing broken");

  // Masking rather than slicing keeps this legal when every pin is present
  AST_ABSENT_IRQ: assert property (@(posedge clk) disable iff (!rstn)
      (external_irq & ~PIN_MASK[MAX_PINS-1:0]) == '0)
    else $error("absent pin raised irq");

  sequence s_word_wr_edge;
    ce && bus_req.wr && bus_req.word && (bus_req.addr == ADDR_EDGE_LOW);
  endsequence

  sequence s_rd_unmapped;
    bus_req.rd && (bus_req.addr != ADDR_EDGE_LOW) && (bus_req.addr != ADDR_EDGE_HIGH)
    && (bus_req.addr != ADDR_SAMPLE_SEL) && (bus_req.addr != ADDR_PIN_LEVEL)
    && (bus_req.addr != ADDR_PULL_LOW) && (bus_req.addr != ADDR_PULL_HIGH);
  endsequence

  AST_EDGE_WORD: assert property (@(posedge clk) disable iff (!rstn)
      s_word_wr_edge |=> (edge_low_r == ($past(bus_req.wdata[REG_W-1:0]) & EDGE_MASK))
                         && (edge_high_r == ($past(bus_req.wdata[DATA_W-1:REG_W]) & EDGE_MASK)))
    else $error("edge word write not paired");

  AST_EDGE_WORD_READ: assert property (@(posedge clk) disable iff (!rstn)
      (bus_req.rd && bus_req.word && bus_req.addr == ADDR_EDGE_LOW)
      |=> bus_rdata == {$past(edge_high_r), $past(edge_low_r)})
    else $error("edge word read not paired");

  AST_EDGE_HIGH_BYTE: assert property (@(posedge clk) disable iff (!rstn)
      (ce && bus_req.wr && bus_req.addr == ADDR_EDGE_HIGH)
      |=> (edge_high_r == ($past(bus_req.wdata[REG_W-1:0]) & EDGE_MASK)) && $stable(edge_low_r))
    else $error("edge high byte write wrong");

  AST_SAMPLE_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      (ce && bus_req.wr && bus_req.addr == ADDR_SAMPLE_SEL)
      |=> sample_sel_r == ($past(bus_req.wdata[REG_W-1:0]) & EDGE_MASK))
    else $error("sampling select write wrong");

  AST_PULL_LOW_BYTE: assert property (@(posedge clk) disable iff (!rstn)
      (ce && bus_req.wr && !bus_req.word && bus_req.addr == ADDR_PULL_LOW)
      |=> $stable(pull_high_r))
    else $error("pull byte write touched pull high");

  // A frozen cycle must not let a write slip through
  AST_FROZEN_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      (!ce && bus_req.wr) |=> $stable(edge_low_r) && $stable(edge_high_r)
          && $stable(sample_sel_r) && $stable(pull_low_r) && $stable(pull_high_r))
    else $error("write taken while frozen");

  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rstn)
      s_rd_unmapped |=> bus_rdata == '0)
    else $error("unmapped read not zero");

  AST_PULL_MASKED: assert property (@(posedge clk) disable iff (!rstn)
      ((pull_low_r | pull_high_r) & ~PIN_MASK) == '0)
    else $error("absent pull bits set");

  AST_PULL_DOWN_MAP: assert property (@(posedge clk) disable iff (!rstn)
      pull_down_en == (pull_low_r[MAX_PINS-1:0] & ~pull_high_r[MAX_PINS-1:0]))
    else $error("pull-down decode wrong");

  AST_PULL_UP_MAP: assert property (@(posedge clk) disable iff (!rstn)
      pull_up_en == (pull_high_r[MAX_PINS-1:0] & ~pull_low_r[MAX_PINS-1:0]))
    else $error("pull-up decode wrong");

  AST_PULL_EXCLUSIVE: assert property (@(posedge clk) disable iff (!rstn)
      (pull_up_en & pull_down_en) == '0)
    else $error("pull-up and pull-down both on");

endmodule : ipz_port_zero

// *** src/ipz_pkg.sv ***
// Constants and carrier types for the port-zero input block with edge interrupts.
// Assumes a byte-addressed register port and a slow sampling tick from outside.

package ipz_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int REG_W     = 8;
  localparam int MAX_PINS  = 6;

  // ==========================================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_EDGE_LOW   = 16'hf038;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_HIGH  = 16'hf039;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE_SEL = 16'hf03a;
  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL  = 16'hf20c;
  localparam logic [ADDR_W-1:0] ADDR_PULL_LOW   = 16'hf20e;
  localparam logic [ADDR_W-1:0] ADDR_PULL_HIGH  = 16'hf20f;

  // ==========================================================================
  // Reset values and masks
  localparam logic [REG_W-1:0] RESET_CTRL  = 8'h00;
  localparam logic [REG_W-1:0] PORT3_MASK  = 8'hc0;
  localparam logic [REG_W-1:0] ZERO_BYTE   = 8'h00;
  localparam logic [REG_W-1:0] PIN_MASK6   = 8'h3f;
  localparam logic [REG_W-1:0] PIN_MASK5   = 8'h1f;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] PULL_HIZ   = 2'h0;
  localparam logic [1:0] PULL_DOWN  = 2'h1;
  localparam logic [1:0] PULL_UP    = 2'h2;
  localparam logic [1:0] EDGE_OFF   = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;
  localparam logic [1:0] EDGE_RISE  = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              word;
    logic              wr;
    logic              rd;
  } ipz_bus_req_t;

endpackage : ipz_pkg

// *** src/ipz_pull_decode.sv ***
// Pull-mode decoder: two select bits per pin into pull-up and pull-down enables.
// Assumes select bits come straight from the pull registers.
`timescale 1ns/1ps

module ipz_pull_decode #(
  parameter int WIDTH = 6
) (
  // Select bits
  input  wire logic [WIDTH-1:0] pull_select_low_bit,
  input  wire logic [WIDTH-1:0] pull_select_high_bit,
  // Pad controls
  output logic      [WIDTH-1:0] pull_up_en,
  output logic      [WIDTH-1:0] pull_down_en
);
  import ipz_pkg::*;

  // ==========================================================================
  // Decode; code 11 falls back to high impedance
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pull_up_en[i]   = ({pull_select_high_bit[i], pull_select_low_bit[i]} == PULL_UP);
      pull_down_en[i] = ({pull_select_high_bit[i], pull_select_low_bit[i]} == PULL_DOWN);
    end
  end

endmodule : ipz_pull_decode

// *** src/ipz_edge_bit.sv ***
// One pin's edge detector with optional sampling on the slow tick.
// Assumes the pin is synchronous to clk and the tick is a one-cycle pulse.
`timescale 1ns/1ps

module ipz_edge_bit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // Pin and tick
  input  wire logic       pin,
  input  wire logic       slow_sampling_tick,
  // Settings
  input  wire logic [1:0] edge_mode,
  input  wire logic       sample_sel,
  // Interrupt request
  output logic            irq
);
  import ipz_pkg::*;

  logic samp_r, samp_nxt;
  logic prev_r, prev_nxt;
  logic primed_r, primed_nxt;
  logic irq_r, irq_nxt;
  logic src, rise, fall;

  // ==========================================================================
  // Next state
  always_comb begin
    samp_nxt   = slow_sampling_tick ? pin : samp_r;
    src        = sample_sel ? samp_r : pin;
    rise       = primed_r & src & ~prev_r;
    fall       = primed_r & ~src & prev_r;
    prev_nxt   = src;
    // No edge is reported before a first level has been seen
    primed_nxt = 1'b1;
    case (edge_mode)
      EDGE_FALL: irq_nxt = fall;
      EDGE_RISE: irq_nxt = rise;
      EDGE_BOTH: irq_nxt = rise | fall;
      default:   irq_nxt = 1'b0;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      samp_r   <= 1'b0;
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
      irq_r    <= 1'b0;
    end else if (ce) begin
      samp_r   <= samp_nxt;
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ==========================================================================
  // Checks
  sequence s_held3;
    ce && $past(ce) && $past(ce, 2);
  endsequence

  property p_direct(logic [1:0] mode, logic lvl);
    @(posedge clk) disable iff (!rstn)
      (s_held3 and (pin == lvl) && ($past(pin) != lvl) && primed_r && !sample_sel
       && (edge_mode == mode)) |=> irq;
  endproperty

  AST_RISE_DIRECT: assert property (p_direct(EDGE_RISE, 1'b1))
    else $error("rising edge missed");
  AST_FALL_DIRECT: assert property (p_direct(EDGE_FALL, 1'b0))
    else $error("falling edge missed");

  AST_NO_IRQ_DISABLED: assert property (@(posedge clk) disable iff (!rstn)
      ($past(ce) && $past(edge_mode) == EDGE_OFF) |-> !irq)
    else $error("irq while disabled");

  AST_SAMPLE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      !slow_sampling_tick |=> $stable(samp_r))
    else $error("sample moved without tick");

  AST_SAMPLED_NEEDS_TICK: assert property (@(posedge clk) disable iff (!rstn)
      (irq && $past(ce) && $past(ce, 2) && $past(sample_sel) && $past(sample_sel, 2)
       && $past(primed_r, 2)) |-> $past(slow_sampling_tick, 2))
    else $error("sampled irq without tick");

endmodule : ipz_edge_bit

// *** sim/ipz_pin_model.sv ***
// Far-side model of the port-zero pins and of the slow sampling tick.
// Assumes the bench calls its tasks; pins change only just after a rising clk edge.
`timescale 1ns/1ps

module ipz_pin_model (
  // Clock
  input  wire logic       clk,
  // Pad pull controls from the block
  input  wire logic [5:0] pull_up_en,
  input  wire logic [5:0] pull_down_en,
  // Pins and tick towards the block
  output logic      [5:0] pin_in,
  output logic            slow_sampling_tick
);
  // ==========================================================================
  // Pin drivers
  logic [5:0] drive_en;
  logic [5:0] drive_val;
  logic       flip;

  initial begin
    drive_en           = 6'h00;
    drive_val          = 6'h00;
    flip               = 1'b0;
    slow_sampling_tick = 1'b0;
  end

  always @(posedge clk) begin
    flip <= ~flip;
  end

  // Floating pins wander every cycle so a stale level never passes for a pull
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (drive_en[i]) begin
        pin_in[i] = drive_val[i];
      end else if (pull_up_en[i]) begin
        pin_in[i] = 1'b1;
      end else if (pull_down_en[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = flip ^ i[0];
      end
    end
  end

  task drive(input logic [5:0] en, input logic [5:0] val);
    @(posedge clk);
    drive_en  <= en;
    drive_val <= val;
  endtask : drive

  // ==========================================================================
  // Slow time base output: one-cycle pulse
  task tick;
    @(posedge clk);
    slow_sampling_tick <= 1'b1;
    @(posedge clk);
    slow_sampling_tick <= 1'b0;
  endtask : tick

endmodule : ipz_pin_model

// *** sim/ipz_port_zero_bench.sv ***
// Self-checking bench for the port-zero block, six-pin and five-pin variants.
// Assumes ipz_pkg, the design sources and the pin model are compiled first.
`timescale 1ns/1ps

module ipz_port_zero_bench;
  import ipz_pkg::*;

  // ==========================================================================
  // Signals
  logic                clk;
  logic                rstn;
  logic                ce;
  ipz_bus_req_t        bus_req;
  logic [DATA_W-1:0]   bus_rdata;
  logic [DATA_W-1:0]   rdata5;
  logic [MAX_PINS-1:0] pin_in;
  logic [MAX_PINS-1:0] pull_up_en;
  logic [MAX_PINS-1:0] pull_down_en;
  logic [MAX_PINS-1:0] external_irq;
  logic [MAX_PINS-1:0] irq5;
  logic [MAX_PINS-1:0] irq_or;
  logic                slow_sampling_tick;
  logic                ev_a;
  logic                ev_b;
  logic                rx0;
  logic                rx1;
  logic [DATA_W-1:0]   rd_q;
  logic [DATA_W-1:0]   rd5_q;
  int                  failures;
  int                  total_checks;
  int                  hit_all;
  int                  hit_other;
  int                  hit5;

  ipz_port_zero #(.NUM_PINS(6)) DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .slow_sampling_tick(slow_sampling_tick),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .pwm_unit_a_event_in(ev_a), .pwm_unit_b_event_in(ev_b),
    .serial0_receive_in(rx0), .serial1_receive_in(rx1), .external_irq(external_irq));

  // Small variant shares every input; only its read data and requests are judged
  ipz_port_zero #(.NUM_PINS(5)) DUT5 (
    .clk(clk), .rstn(rstn), .ce(ce), .bus_req(bus_req), .bus_rdata(rdata5),
    .pin_in(pin_in), .slow_sampling_tick(slow_sampling_tick),
    .pull_up_en(), .pull_down_en(), .pwm_unit_a_event_in(), .pwm_unit_b_event_in(),
    .serial0_receive_in(), .serial1_receive_in(), .external_irq(irq5));

  ipz_pin_model pins (
    .clk(clk), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .pin_in(pin_in), .slow_sampling_tick(slow_sampling_tick));

  always #10 clk = ~clk;

  // ==========================================================================
  // Shared tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, word: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [15:0] a, input logic w);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0000, word: w, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    rd_q  = bus_rdata;
    rd5_q = rdata5;
    @(negedge clk);
    check(bus_rdata, 16'h0000);
  endtask : rd

  // Counts cycles with every request up and with any other nonzero pattern
  task watch(input int n);
    hit_all   = 0;
    hit_other = 0;
    irq_or    = 6'h00;
    repeat (n) begin
      @(negedge clk);
      irq_or = irq_or | external_irq;
      if (external_irq === 6'h3f) hit_all++;
      else if (external_irq !== 6'h00) hit_other++;
      if (irq5[5] !== 1'b0) hit5++;
    end
  endtask : watch

  // ==========================================================================
  // Scenarios
  task t_reset;
    logic [15:0] addrs [5];
    addrs = '{ADDR_EDGE_LOW, ADDR_EDGE_HIGH, ADDR_SAMPLE_SEL, ADDR_PULL_LOW, ADDR_PULL_HIGH};
    foreach (addrs[i]) begin
      rd(addrs[i], 1'b0);
      check(rd_q, 16'h0000);
    end
    rd(16'hf100, 1'b0);
    check(rd_q, 16'h0000);
    check({4'h0, pull_up_en, pull_down_en}, 16'h0000);
    $display("test reset values finished");
  endtask : t_reset

  task t_regs;
    wr(ADDR_PULL_LOW, 16'h00ff, 1'b0);
    rd(ADDR_PULL_LOW, 1'b0);
    check(rd_q, 16'h003f);
    wr(ADDR_EDGE_HIGH, 16'h00c5, 1'b0);
    rd(ADDR_EDGE_HIGH, 1'b0);
    check(rd_q, 16'h00c5);
    wr(ADDR_PULL_LOW, 16'h2a15, 1'b1);
    rd(ADDR_PULL_LOW, 1'b1);
    check(rd_q, 16'h2a15);
    check({4'h0, pull_up_en, pull_down_en}, 16'h0a95);
    wr(ADDR_PULL_LOW, 16'h3f3f, 1'b1);
    rd(ADDR_PULL_HIGH, 1'b0);
    check(rd_q, 16'h003f);
    check({4'h0, pull_up_en, pull_down_en}, 16'h0000);
    wr(ADDR_EDGE_HIGH, 16'h0000, 1'b0);
    wr(ADDR_PULL_LOW, 16'h0000, 1'b1);
    wr(ADDR_PULL_HIGH, 16'h0021, 1'b0);
    @(negedge clk);
    check({4'h0, pull_up_en, pull_down_en}, 16'h0840);
    wr(ADDR_PULL_HIGH, 16'h0000, 1'b0);
    // Frozen block drops the write
    @(posedge clk);
    ce <= 1'b0;
    wr(ADDR_SAMPLE_SEL, 16'h003f, 1'b0);
    ce <= 1'b1;
    rd(ADDR_SAMPLE_SEL, 1'b0);
    check(rd_q, 16'h0000);
    $display("test register access finished");
  endtask : t_regs

  task t_pins;
    pins.drive(6'h3f, 6'h2d);
    rd(ADDR_PIN_LEVEL, 1'b0);
    check(rd_q, 16'h002d);
    check(rd5_q, 16'h000d);
    check({12'h000, rx1, rx0, ev_b, ev_a}, 16'h000d);
    wr(ADDR_PIN_LEVEL, 16'h0000, 1'b0);
    rd(ADDR_PIN_LEVEL, 1'b0);
    check(rd_q, 16'h002d);
    pins.drive(6'h00, 6'h00);
    wr(ADDR_PULL_LOW, 16'h3f00, 1'b1);
    rd(ADDR_PIN_LEVEL, 1'b0);
    check(rd_q, 16'h003f);
    wr(ADDR_PULL_LOW, 16'h003f, 1'b1);
    rd(ADDR_PIN_LEVEL, 1'b0);
    check(rd_q, 16'h0000);
    pins.drive(6'h3f, 6'h00);
    wr(ADDR_PULL_LOW, 16'h0000, 1'b1);
    $display("test pin levels finished");
  endtask : t_pins

  task t_edges;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(ADDR_EDGE_LOW, {m[1] ? 8'h3f : 8'h00, m[0] ? 8'h3f : 8'h00}, 1'b1);
      pins.drive(6'h3f, 6'h3f);
      watch(4);
      check(hit_all[15:0], {15'h0, m[1]});
      check(hit_other[15:0], 16'h0000);
      pins.drive(6'h3f, 6'h00);
      watch(4);
      check(hit_all[15:0], {15'h0, m[0]});
      check(hit_other[15:0], 16'h0000);
    end
    wr(ADDR_EDGE_LOW, 16'h3f00, 1'b1);
    rd(ADDR_EDGE_LOW, 1'b1);
    check(rd_q, 16'h3f00);
    pins.drive(6'h3f, 6'h10);
    watch(4);
    check({10'h000, irq_or}, 16'h0010);
    check(hit5[15:0], 16'h0000);
    $display("test edge modes finished");
  endtask : t_edges

  task t_sampled;
    wr(ADDR_EDGE_LOW, 16'h0000, 1'b1);
    pins.drive(6'h3f, 6'h00);
    pins.tick;
    wr(ADDR_SAMPLE_SEL, 16'h003f, 1'b0);
    wr(ADDR_EDGE_LOW, 16'h3f00, 1'b1);
    pins.drive(6'h3f, 6'h3f);
    watch(6);
    check(hit_all[15:0], 16'h0000);
    pins.tick;
    watch(4);
    check(hit_all[15:0], 16'h0001);
    check(hit_other[15:0], 16'h0000);
    $display("test sampled detection finished");
  endtask : t_sampled

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Whole run is well under a thousand cycles; this allows a wide margin
  initial begin
    #200000;
    failures++;
    $display("ERROR t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    clk          = 1'b0;
    rstn         = 1'b0;
    ce           = 1'b1;
    bus_req      = '0;
    failures     = 0;
    total_checks = 0;
    hit5         = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_pins();
    t_edges();
    t_sampled();
    conclude();
  end

endmodule : ipz_port_zero_bench
